/* File: rtl/map_cache.sv */
// expansion-bus map cache, cpu window translation and communication register
`default_nettype none
module map_cache
  import map_cache_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic dc_power_ok_in,
  input wire logic io_reset_write_in,
  // expansion-bus dma translation request
  input wire logic xlate_req_in,
  input wire logic [21:0] xlate_addr_in,
  output logic xlate_done_out,
  output logic xlate_ok_out,
  output logic [28:0] xlate_mem_addr_out,
  // memory-resident map fetch
  input wire logic [16:0] map_base_in,
  output logic map_rd_req_out,
  output logic [31:0] map_rd_addr_out,
  input wire logic map_rd_ack_in,
  input wire logic [31:0] map_rd_data_in,
  // invalidation sources
  input wire logic map_base_write_in,
  input wire logic map_reg_write_in,
  input wire logic [12:0] map_reg_write_page_in,
  // cpu window translation
  input wire logic [31:0] cpu_addr_in,
  output logic cpu_win_hit_out,
  output logic [21:0] cpu_bus_addr_out,
  output logic cpu_bus_bbs7_out,
  output logic bus_arbiter_out,
  // communication register access
  input wire logic reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic [1:0] reg_byte_en_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic self_master_in,
  output logic [15:0] reg_rdata_out,
  // error and doorbell sources
  input wire logic dma_memory_error_in,
  input wire logic cpu_bus_timeout_in,
  input wire logic doorbell_grant_in,
  output logic doorbell_irq_request_out,
  output logic local_memory_external_access_out
);
  logic dc_power_ok_s1_r;
  logic dc_power_ok_s2_r;
  logic dc_power_ok_prev_r;
  logic [ENTRY_VALID_BIT:0] entry_r [ENTRIES];
  logic [IDX_W-1:0] victim_r;
  xlate_state_t state_r;
  xlate_state_t state_nxt;
  logic [21:0] pend_addr_r;
  logic done_ok_r;
  logic [28:0] mem_addr_r;
  logic mem_err_r;
  logic aux_halt_r;
  logic db_enable_r;
  logic lm_access_r;
  logic db_req_r;
  logic dma_err_prev_r;

  // dc_power_ok comes from a pin: synchronise before use
  always_ff @(posedge clk_sys_in)
  begin
    dc_power_ok_s1_r <= dc_power_ok_in;
    dc_power_ok_s2_r <= dc_power_ok_s1_r;
  end

  // edge history starts high so that a supply still low when reset ends is taken for a power drop
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      dc_power_ok_prev_r <= 1'b1;
    else
      dc_power_ok_prev_r <= dc_power_ok_s2_r;
  end

  wire dc_power_ok_fall = dc_power_ok_prev_r & ~dc_power_ok_s2_r;
  wire power_clr = rst_in | dc_power_ok_fall;
  wire io_clr = power_clr | io_reset_write_in;

  function automatic logic tag_match(input logic [ENTRY_VALID_BIT:0] e, input logic [TAG_W-1:0] t);
    tag_match = e[ENTRY_VALID_BIT] & (e[32:FRAME_W] == t);
  endfunction : tag_match

  wire [TAG_W-1:0] look_tag = pend_addr_r[21:9]; // see RULE2
  logic [ENTRIES-1:0] hit_vec;
  logic [ENTRIES-1:0] inval_vec;
  logic [ENTRIES-1:0] empty_vec;
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_cam
      assign hit_vec[g] = tag_match(entry_r[g], look_tag); // see RULE1
      assign empty_vec[g] = ~entry_r[g][ENTRY_VALID_BIT];
    end
  endgenerate

  // a map register write kills only its own cached copy; other entries stay
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_kill
      assign inval_vec[g] = tag_match(entry_r[g], map_reg_write_page_in) & map_reg_write_in; // see RULE7
    end
  endgenerate

  logic [IDX_W-1:0] hit_idx;
  logic [IDX_W-1:0] free_idx;

  // lowest set bit wins; used both for the hit entry and for the first free slot
  function automatic logic [IDX_W-1:0] lowest_set(input logic [ENTRIES-1:0] v);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (v[i])
        idx = IDX_W'(i);
    end
    lowest_set = idx;
  endfunction : lowest_set

  assign hit_idx = lowest_set(hit_vec);
  // a free slot is always preferred, so the pointer only matters once the cache is full
  assign free_idx = (|empty_vec) ? lowest_set(empty_vec) : victim_r; // see RULE20

  wire cache_hit = |hit_vec;
  wire [FRAME_W-1:0] hit_frame = entry_r[hit_idx][FRAME_W-1:0];

  // comm register write decode
  wire reg_write = reg_sel_in & reg_wr_in;
  wire wr_lo = reg_write & reg_byte_en_in[0]; // see RULE12
  wire wr_hi = reg_write & reg_byte_en_in[1]; // see RULE12
  wire inval_all_wr = wr_hi & reg_wdata_in[INVAL_ALL_BIT]; // see RULE15
  wire flush_all = io_clr | inval_all_wr | map_base_write_in; // see RULE7

  wire fetch_valid = map_rd_data_in[MAP_VALID_BIT];
  wire store_entry = (state_r == ST_FETCH) & map_rd_ack_in & fetch_valid & ~flush_all; // see RULE3

  // fetch sequencing: requests that arrive while busy are not taken
  always_comb
  begin
    case (state_r)
      ST_IDLE:
      begin
        if (xlate_req_in)
          state_nxt = ST_FETCH;
        else
          state_nxt = ST_IDLE;
      end
      ST_FETCH:
      begin
        if (cache_hit)
          state_nxt = ST_DONE; // see RULE5
        else if (map_rd_ack_in)
          state_nxt = ST_DONE; // see RULE3
        else
          state_nxt = ST_FETCH;
      end
      ST_DONE:
      begin
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // first cycle in fetch state tries the cache; a miss holds the memory read open
  assign map_rd_req_out = (state_r == ST_FETCH) & ~cache_hit; // see RULE6
  assign map_rd_addr_out = {map_base_in[16:0], look_tag, 2'b00}; // see RULE2
  assign xlate_done_out = (state_r == ST_DONE);
  assign xlate_ok_out = done_ok_r;
  assign xlate_mem_addr_out = mem_addr_r;

  wire in_idle = (state_r == ST_IDLE);
  wire in_fetch = (state_r == ST_FETCH);
  wire take_req = in_idle & xlate_req_in;
  wire fetch_hit = in_fetch & cache_hit;
  wire fetch_ack = in_fetch & ~cache_hit & map_rd_ack_in;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // the address is held for the whole fetch so the lookup tag cannot move under it
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      pend_addr_r <= '0;
    else if (take_req)
      pend_addr_r <= xlate_addr_in;
  end

  // a hit is not gated by the local access enable; only the memory path is
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      done_ok_r <= 1'b0;
      mem_addr_r <= '0;
    end
    else if (fetch_hit)
    begin
      done_ok_r <= 1'b1;
      mem_addr_r <= {hit_frame, pend_addr_r[8:0]}; // see RULE5
    end
    else if (fetch_ack)
    begin
      done_ok_r <= fetch_valid & lm_access_r; // see RULE19
      mem_addr_r <= {map_rd_data_in[FRAME_W-1:0], pend_addr_r[8:0]}; // see RULE5
    end
  end

  // entries: flags cleared by flushes, single entry cleared on a write to its map register
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_entry
      wire load_here = store_entry & (free_idx == IDX_W'(g));
      always_ff @(posedge clk_sys_in)
      begin
        if (flush_all)
        begin
          entry_r[g][ENTRY_VALID_BIT] <= 1'b0; // see RULE7
        end
        else if (load_here)
        begin
          entry_r[g] <= {1'b1, look_tag, map_rd_data_in[FRAME_W-1:0]}; // see RULE4
        end
        else if (inval_vec[g])
        begin
          entry_r[g][ENTRY_VALID_BIT] <= 1'b0; // see RULE7
        end
      end
    end
  endgenerate

  // the pointer only moves when a full cache is forced to evict
  wire evict = store_entry & ~|empty_vec;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      victim_r <= '0;
    end
    else if (evict)
    begin
      victim_r <= victim_r + 1'b1; // see RULE20
    end
  end

  // cpu window translation
  wire in_io_win = (cpu_addr_in >= IO_WIN_BASE) & (cpu_addr_in <= IO_WIN_LAST);
  wire in_mem_win = (cpu_addr_in >= MEM_WIN_BASE) & (cpu_addr_in <= MEM_WIN_LAST);
  assign cpu_win_hit_out = in_io_win | in_mem_win;
  // both windows decode in parallel; they cannot overlap
  wire [21:0] io_bus_addr = {9'h000, cpu_addr_in[12:0]}; // see RULE8
  wire [21:0] mem_bus_addr = cpu_addr_in[21:0]; // see RULE9
  assign cpu_bus_addr_out = in_io_win ? io_bus_addr : (in_mem_win ? mem_bus_addr : 22'h00_0000);
  assign cpu_bus_bbs7_out = in_io_win; // see RULE8
  assign bus_arbiter_out = 1'b1; // see RULE10

  // communication register
  wire dma_err_fall = dma_err_prev_r & ~dma_memory_error_in;
  wire dma_err_rise = dma_memory_error_in & ~dma_err_prev_r;
  wire mem_err_set = dma_err_rise | cpu_bus_timeout_in;
  wire mem_err_wclr = wr_hi & reg_wdata_in[MEM_ERR_BIT];
  // only the device itself as bus master may change the enables
  wire own_lo = wr_lo & self_master_in;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      dma_err_prev_r <= 1'b0;
    else
      dma_err_prev_r <= dma_memory_error_in;
  end

  // a new error outranks a clear in the same cycle so it is never lost
  always_ff @(posedge clk_sys_in)
  begin
    if (mem_err_set)
      mem_err_r <= 1'b1; // see RULE13
    else if (io_clr | mem_err_wclr | dma_err_fall)
      mem_err_r <= 1'b0; // see RULE14
  end

  // nothing sets the halt flag: auxiliary mode is not supported
  always_ff @(posedge clk_sys_in)
  begin
    if (io_clr)
      aux_halt_r <= 1'b0; // see RULE17
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (io_clr)
      db_enable_r <= 1'b0;
    else if (own_lo)
      db_enable_r <= reg_wdata_in[DB_ENABLE_BIT];
  end

  // the i/o reset write leaves the local access enable alone; only power events clear it
  always_ff @(posedge clk_sys_in)
  begin
    if (power_clr)
      lm_access_r <= 1'b0; // see RULE19
    else if (own_lo)
      lm_access_r <= reg_wdata_in[LM_ACCESS_BIT];
  end

  // request wins over a same-cycle grant so a new ring is not lost
  always_ff @(posedge clk_sys_in)
  begin
    if (power_clr | ~db_enable_r)
      db_req_r <= 1'b0;
    else if (wr_lo && reg_wdata_in[DB_REQUEST_BIT])
      db_req_r <= 1'b1; // see RULE18
    else if (doorbell_grant_in)
      db_req_r <= 1'b0; // see RULE18
  end

  // unused bits and the invalidate strobe read back as zero
  wire [7:0] rd_hi = {mem_err_r, 6'b00_0000, aux_halt_r}; // see RULE16
  wire [7:0] rd_lo = {1'b0, db_enable_r, lm_access_r, 4'h0, db_req_r}; // see RULE16
  assign reg_rdata_out = {rd_hi, rd_lo}; // see RULE11
  assign doorbell_irq_request_out = db_req_r;
  assign local_memory_external_access_out = lm_access_r;
endmodule : map_cache
`default_nettype wire

/* File: rtl/map_cache_pkg.sv */
// constants and types for the expansion-bus map translation cache
// Notes on behaviour
// RULE1: sixteen-entry fully associative cache of map register copies
// RULE2: look up by bus address 21:9; on miss read entry at map base
// RULE3: fetched entry with valid bit set is stored; pending cycle proceeds
// RULE4: entry holds valid flag 33, tag 32:20, page frame 19:0
// RULE5: hit gives memory address 28:9 from frame, bits 8:0 pass through
// RULE6: no valid cached entry means reading the memory map instead
// RULE7: valid flags clear on resets, invalidate-all, base write, cached map write
// RULE8: cpu 2000_0000..2000_1FFF maps to bus io page, bbs7 set, upper bits zero
// RULE9: cpu 3000_0000..303F_FFFF maps to bus memory with address bits 21:0
// RULE10: device is always the bus arbiter, never a plain participant
// RULE11: 16-bit comm register at 2000_1F40, open to every bus master; enable bits 6 and 5 change only on writes with self_master_in set
// RULE12: byte writes change only the addressed byte
// RULE13: memory error bit 15 sets on dma memory error rise or cpu-bus timeout
// RULE14: memory error clears on write one, resets, or dma error bit clearing
// RULE15: writing one to bit 14 invalidates all entries; reads zero
// RULE16: bits 13:9 and 7 read zero and are written zero
// RULE17: auxiliary halt bit 8 is read-only, cleared by resets, no cpu effect
// RULE18: with enable bit 6 set, writing one to bit 0 raises doorbell until granted
// RULE19: bit 5 gates external access to local memory, cleared by power resets; here it gates only translations read from memory, not cache hits
// RULE20: when all entries are in use, a round-robin pointer picks the victim
`default_nettype none
package map_cache_pkg;
  localparam int ENTRIES = 16;
  localparam int IDX_W = 4;
  localparam int TAG_W = 13;
  localparam int FRAME_W = 20;
  localparam int ENTRY_VALID_BIT = 33;
  localparam int MAP_VALID_BIT = 31;
  localparam logic [31:0] COMM_REG_ADDR = 32'h2000_1f40;
  localparam logic [31:0] IO_WIN_BASE = 32'h2000_0000;
  localparam logic [31:0] IO_WIN_LAST = 32'h2000_1fff;
  localparam logic [31:0] MEM_WIN_BASE = 32'h3000_0000;
  localparam logic [31:0] MEM_WIN_LAST = 32'h303f_ffff;
  localparam int MEM_ERR_BIT = 15;
  localparam int INVAL_ALL_BIT = 14;
  localparam int AUX_HALT_BIT = 8;
  localparam int DB_ENABLE_BIT = 6;
  localparam int LM_ACCESS_BIT = 5;
  localparam int DB_REQUEST_BIT = 0;
  localparam logic [15:0] COMM_RESET = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_DONE = 3'b100
  } xlate_state_t;
endpackage : map_cache_pkg
`default_nettype wire

/* File: sim/map_cache_monitor.sv */
// port-level checker for the map cache
`default_nettype none
module map_cache_monitor
  import map_cache_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [21:0] xlate_addr_in,
  input wire logic xlate_done_out,
  input wire logic xlate_ok_out,
  input wire logic [28:0] xlate_mem_addr_out,
  input wire logic [16:0] map_base_in,
  input wire logic map_rd_req_out,
  input wire logic [31:0] map_rd_addr_out,
  input wire logic map_rd_ack_in,
  input wire logic [31:0] cpu_addr_in,
  input wire logic cpu_win_hit_out,
  input wire logic [21:0] cpu_bus_addr_out,
  input wire logic cpu_bus_bbs7_out,
  input wire logic bus_arbiter_out,
  input wire logic [15:0] reg_rdata_out,
  input wire logic cpu_bus_timeout_in,
  input wire logic doorbell_irq_request_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_arb; bus_arbiter_out; endproperty
  a_arb: assert property (p_arb) else $error("arbiter low");
  property p_io; cpu_addr_in >= IO_WIN_BASE && cpu_addr_in <= IO_WIN_LAST
    |-> cpu_win_hit_out && cpu_bus_bbs7_out && cpu_bus_addr_out == {9'h000, cpu_addr_in[12:0]}; endproperty
  a_io: assert property (p_io) else $error("io window");
  property p_mem; cpu_addr_in >= MEM_WIN_BASE && cpu_addr_in <= MEM_WIN_LAST
    |-> cpu_win_hit_out && cpu_bus_addr_out == cpu_addr_in[21:0]; endproperty
  a_mem: assert property (p_mem) else $error("mem window");
  property p_rdaddr; map_rd_req_out |-> map_rd_addr_out == {map_base_in, xlate_addr_in[21:9], 2'b00}; endproperty
  a_rdaddr: assert property (p_rdaddr) else $error("map address");
  property p_fetch; map_rd_req_out && map_rd_ack_in |=> xlate_done_out && !map_rd_req_out; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch end");
  property p_low; xlate_done_out && xlate_ok_out |-> xlate_mem_addr_out[8:0] == xlate_addr_in[8:0]; endproperty
  a_low: assert property (p_low) else $error("offset");
  property p_zero; reg_rdata_out[14:7] == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("zero bits");
  property p_merr; cpu_bus_timeout_in |=> reg_rdata_out[15]; endproperty
  a_merr: assert property (p_merr) else $error("error flag");
  property p_db; !reg_rdata_out[6] |=> !doorbell_irq_request_out; endproperty
  a_db: assert property (p_db) else $error("doorbell");
  c_miss: cover property (map_rd_req_out && map_rd_ack_in);
  c_ok: cover property (xlate_done_out && xlate_ok_out);
  c_db: cover property (doorbell_irq_request_out);
endmodule : map_cache_monitor
bind map_cache map_cache_monitor u_mon (.*);
`default_nettype wire

/* File: sim/map_memory_model.sv */
// memory-resident map answering the fetch port
`default_nettype none
module map_memory_model
(
  input wire logic clk_in,
  input wire logic [3:0] wait_in,
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  output logic ack_out,
  output logic [31:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  logic [12:0] page;
  // pages with the top tag bit set are unmapped
  assign page = addr_in[14:2];
  initial
  begin
    ack_out = 0;
    data_out = 32'h0000_0000;
    cnt_r = 0;
  end
  always @(posedge clk_in)
  begin
    #1;
    ack_out = 0;
    data_out = ~data_out; // released lines never keep the last word
    if (!req_in)
      cnt_r = 0;
    else if (cnt_r < wait_in)
      cnt_r++;
    else
    begin
      ack_out = 1;
      data_out = {~page[12], 11'h000, 7'h55, page};
      cnt_r = 0;
    end
  end
endmodule : map_memory_model
`default_nettype wire

/* File: sim/test_map_cache.sv */
// self-checking bench for the map cache
`default_nettype none
module test_map_cache;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in, rst_in, dc_power_ok_in, io_reset_write_in, xlate_req_in, xlate_done_out, xlate_ok_out;
  logic map_rd_req_out, map_rd_ack_in, map_base_write_in, map_reg_write_in, cpu_win_hit_out, cpu_bus_bbs7_out;
  logic bus_arbiter_out, reg_sel_in, reg_wr_in, self_master_in, dma_memory_error_in, cpu_bus_timeout_in;
  logic doorbell_grant_in, doorbell_irq_request_out, local_memory_external_access_out;
  logic [21:0] xlate_addr_in, cpu_bus_addr_out;
  logic [28:0] xlate_mem_addr_out;
  logic [16:0] map_base_in;
  logic [31:0] map_rd_addr_out, map_rd_data_in, cpu_addr_in;
  logic [12:0] map_reg_write_page_in;
  logic [1:0] reg_byte_en_in;
  logic [15:0] reg_wdata_in, reg_rdata_out;
  logic [3:0] mem_wait;
  int n_fail = 0;
  int checked = 0;
  map_cache u_dut (.*);
  map_memory_model u_mem (.clk_in(clk_sys_in), .wait_in(mem_wait), .req_in(map_rd_req_out),
    .addr_in(map_rd_addr_out), .ack_out(map_rd_ack_in), .data_out(map_rd_data_in));
  always #5 clk_sys_in = ~clk_sys_in;
  task automatic stop_test;
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic ck(input logic c, input string m);
    checked++;
    if (c !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : ck
  task automatic tick;
    @(posedge clk_sys_in);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1;
    tick();
    s = 0;
  endtask : pulse
  task automatic wr(input logic [1:0] be, input logic [15:0] d);
    {reg_sel_in, reg_wr_in, reg_byte_en_in, reg_wdata_in} = {2'b11, be, d};
    tick();
    {reg_sel_in, reg_wr_in} = 2'b00;
  endtask : wr
  // hit answers one loop pass after the request edge; miss goes through the map
  task automatic xl(input logic [21:0] a, input logic hit, input logic ok);
    int n;
    logic miss;
    n = 0;
    miss = 0;
    xlate_addr_in = a;
    pulse(xlate_req_in);
    while (xlate_done_out !== 1'b1 && n < 40)
    begin
      miss |= map_rd_req_out;
      tick();
      n++;
    end
    ck(miss === !hit && (!hit || n == 1), "path");
    ck(xlate_ok_out === ok, "status");
    if (ok)
      ck(xlate_mem_addr_out === {7'h55, a}, "address");
    tick();
  endtask : xl
  task automatic t_win;
    ck(bus_arbiter_out === 1'b1, "arbiter");
    cpu_addr_in = 32'h2000_1f40;
    #1 ck(cpu_win_hit_out && cpu_bus_bbs7_out && cpu_bus_addr_out === 22'h00_1f40, "io");
    cpu_addr_in = 32'h303f_fffe;
    #1 ck(cpu_win_hit_out && cpu_bus_addr_out === 22'h3f_fffe, "mem");
    cpu_addr_in = 32'h2000_2000;
    #1 ck(cpu_win_hit_out === 1'b0, "outside");
  endtask : t_win
  task automatic t_xlate;
    wr(2'b01, 16'h0060);
    ck(reg_rdata_out === 16'h0060, "comm write");
    mem_wait = 3;
    xl(22'h01_2345, 0, 1);
    mem_wait = 0;
    xl(22'h01_23ff, 1, 1);
    xl(22'h20_0100, 0, 0);
    xl(22'h20_0100, 0, 0);
  endtask : t_xlate
  task automatic t_inval;
    map_reg_write_page_in = 13'h0005;
    for (int k = 0; k < 4; k++)
    begin
      xl(22'h00_0a00, 0, 1);
      xl(22'h00_0a00, 1, 1);
      case (k)
        0: wr(2'b10, 16'h4000);
        1: pulse(map_base_write_in);
        2: pulse(io_reset_write_in);
        default: pulse(map_reg_write_in);
      endcase
    end
    xl(22'h00_0a00, 0, 1);
  endtask : t_inval
  task automatic t_fill;
    wr(2'b10, 16'h4000);
    for (int i = 0; i < 16; i++)
      xl(22'(i << 9), 0, 1);
    for (int i = 0; i < 16; i++)
      xl(22'(i << 9), 1, 1);
    xl(22'h00_2000, 0, 1);
    xl(22'h00_2000, 1, 1);
  endtask : t_fill
  task automatic t_reg;
    wr(2'b01, 16'h0040);
    wr(2'b01, 16'h0061);
    ck(doorbell_irq_request_out === 1'b1, "doorbell set");
    pulse(doorbell_grant_in);
    ck(doorbell_irq_request_out === 1'b0, "doorbell grant");
    pulse(cpu_bus_timeout_in);
    wr(2'b01, 16'hff00);
    ck(reg_rdata_out === 16'h8000, "byte write");
    wr(2'b10, 16'h8000);
    ck(reg_rdata_out === 16'h0000, "write clear");
    dma_memory_error_in = 1;
    repeat (3) tick();
    ck(reg_rdata_out[15] === 1'b1, "dma set");
    dma_memory_error_in = 0;
    repeat (3) tick();
    ck(reg_rdata_out[15] === 1'b0, "dma clear");
    pulse(cpu_bus_timeout_in);
    pulse(io_reset_write_in);
    ck(reg_rdata_out[15] === 1'b0, "io reset");
    wr(2'b01, 16'h0020);
    ck(local_memory_external_access_out === 1'b1, "local access on");
    dc_power_ok_in = 0;
    repeat (4) tick();
    dc_power_ok_in = 1;
    repeat (4) tick();
    ck(reg_rdata_out === 16'h0000, "power drop");
    ck(local_memory_external_access_out === 1'b0, "local access off");
    xl(22'h00_2000, 0, 0);
  endtask : t_reg
  initial
  begin
    {clk_sys_in, io_reset_write_in, xlate_req_in, map_base_write_in, map_reg_write_in} = '0;
    {reg_sel_in, reg_wr_in, dma_memory_error_in, cpu_bus_timeout_in, doorbell_grant_in} = '0;
    {xlate_addr_in, cpu_addr_in, map_reg_write_page_in, reg_byte_en_in, reg_wdata_in, mem_wait} = '0;
    {rst_in, dc_power_ok_in, self_master_in} = 3'b111;
    map_base_in = 17'h1_0001;
    repeat (5) tick();
    rst_in = 0;
    t_win();
    t_xlate();
    t_inval();
    t_fill();
    t_reg();
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail++;
    stop_test();
  end
endmodule : test_map_cache
`default_nettype wire
